// file: rtl/sar_seq_pkg.sv
package sar_seq_pkg;

  // Register byte addresses on the Wishbone port.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_RESULT = 8'h08;
  localparam logic [7:0] ADDR_OFFSET = 8'h0c;
  localparam logic [7:0] ADDR_GAIN = 8'h10;

  // Control register field positions.
  localparam int CTRL_W = 21;
  localparam int BIT_START = 0;
  localparam int BIT_CONT = 1;
  localparam int BIT_DIFF = 2;
  localparam int MODE_LSB = 3;
  localparam int BIT_LSMP = 5;
  localparam int LSTS_LSB = 6;
  localparam int BIT_HSC = 9;
  localparam int BIT_AVERAGING_ENABLE = 10;
  localparam int AVGS_LSB = 11;
  localparam int BIT_ASYNC = 13;
  localparam int BIT_KEEP = 14;
  localparam int REF_LSB = 15;
  localparam int DIV_LSB = 17;
  localparam int BIT_CAL = 19;
  localparam int BIT_IE = 20;

  // Status register field positions.
  localparam int BIT_CONVERSION_COMPLETE_FLAG = 0;
  localparam int BIT_BUSY = 1;
  localparam int BIT_CALRUN = 2;
  localparam int BIT_CALFAIL = 3;

  // Values after reset; long sample code 0 is the longest extension.
  localparam logic [CTRL_W-1:0] CTRL_RESET = 21'h000000;
  localparam logic [15:0] OFFSET_RESET = 16'h0000;
  localparam logic [15:0] GAIN_RESET = 16'h8000;

  // Timing figures and their cycle counts at the system clock rate.
  localparam int CLK_MHZ = 100;
  localparam int FIRST_WAKE_US = 5;
  localparam int FIRST_WAKE_CYCLES = FIRST_WAKE_US * CLK_MHZ;
  localparam int FIRST_BUS_CYCLES = 5;
  localparam int FIRST_TICKS_LONG = 3;
  localparam int FIRST_TICKS_SHORT = 5;
  localparam int HSC_TICKS = 4;
  localparam int BCT_SE_8 = 17;
  localparam int BCT_SE_10_12 = 20;
  localparam int BCT_SE_16 = 25;
  localparam int BCT_DIFF_9 = 27;
  localparam int BCT_DIFF_11_13 = 30;
  localparam int BCT_DIFF_16 = 34;
  localparam int LST_0 = 20;
  localparam int LST_1 = 12;
  localparam int LST_2 = 6;
  localparam int LST_3 = 2;
  localparam int CAL_AVG_SHIFT = 5;
  localparam int MIN_DIV = 4;

  typedef enum logic [1:0] {
    RES_8 = 2'b00,
    RES_12 = 2'b01,
    RES_10 = 2'b10,
    RES_16 = 2'b11
  } res_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDER_BUS = 3'b001,
    ST_ADDER_CLK = 3'b010,
    ST_SAMPLE = 3'b011,
    ST_SAR = 3'b100
  } seq_state_t;

endpackage : sar_seq_pkg

// file: rtl/sar_result_corrector.sv
`timescale 1ns/1ps
module sar_result_corrector import sar_seq_pkg::*; (
  // Raw approximation code and format.
  input wire logic [15:0] raw,
  input wire logic diff,
  input wire res_mode_t mode,
  // Correction values, gain is unsigned with 16'h8000 as unity.
  input wire logic [15:0] offset,
  input wire logic [15:0] gain,
  // Corrected, clamped, right-justified result.
  output logic [15:0] corrected
);

  logic [4:0] nbits;
  logic signed [17:0] half;
  logic signed [17:0] hi;
  logic signed [17:0] lo;
  logic signed [17:0] centred;
  logic signed [17:0] minus_off;
  logic signed [34:0] product;
  logic signed [19:0] scaled;
  logic signed [17:0] clamped;

  always_comb begin
    unique case (mode)
      RES_8: nbits = diff ? 5'd9 : 5'd8;
      RES_12: nbits = diff ? 5'd13 : 5'd12;
      RES_10: nbits = diff ? 5'd11 : 5'd10;
      RES_16: nbits = 5'd16;
    endcase
    half = 18'sd1 <<< (nbits - 5'd1);
    // An offset-binary code minus half scale gives plus minus minus, signed.
    centred = diff ? $signed({2'b00, raw}) - half : $signed({2'b00, raw});
    minus_off = centred - $signed({{2{offset[15]}}, offset});
    product = minus_off * $signed({1'b0, gain});
    scaled = product[34:15];
    hi = diff ? half - 18'sd1 : (18'sd1 <<< nbits) - 18'sd1;
    lo = diff ? -half : 18'sd0;
    // Clamping keeps a large correction from wrapping into the wrong sign.
    if (scaled > 20'(hi)) begin
      clamped = hi;
    end else if (scaled < 20'(lo)) begin
      clamped = lo;
    end else begin
      clamped = scaled[17:0];
    end
    corrected = clamped[15:0];
  end

endmodule : sar_result_corrector

// file: rtl/sar_adc_conversion_sequencer.sv
`timescale 1ns/1ps
module sar_adc_conversion_sequencer import sar_seq_pkg::*; #(
  parameter logic [15:0] CAL_OFFSET_LIMIT = 16'h0100
) (
  // Clock, reset and freeze.
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clk_en,
  // Wishbone classic slave.
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Analog front end.
  input wire logic comparator_high,
  input wire logic local_async_clock,
  output logic sample_hold,
  output logic [15:0] dac_code,
  output logic diff_mode,
  output logic [1:0] reference_select,
  output logic cal_short,
  output logic async_clock_request,
  output logic conv_irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  logic comp_s1;
  logic comp_s2;
  logic lac_s1;
  logic lac_s2;
  logic lac_s3;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      comp_s1 <= 1'b0;
      comp_s2 <= 1'b0;
      lac_s1 <= 1'b0;
      lac_s2 <= 1'b0;
      lac_s3 <= 1'b0;
    end else if (clk_en) begin
      comp_s1 <= comparator_high;
      comp_s2 <= comp_s1;
      lac_s1 <= local_async_clock;
      lac_s2 <= lac_s1;
      lac_s3 <= lac_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State.

  seq_state_t state;
  seq_state_t next_state;
  logic [CTRL_W-1:0] ctrl;
  logic [CTRL_W-1:0] next_ctrl;
  logic [15:0] offset;
  logic [15:0] next_offset;
  logic [15:0] gain;
  logic [15:0] next_gain;
  logic [15:0] result;
  logic [15:0] next_result;
  logic conversion_complete_flag;
  logic next_conversion_complete_flag;
  logic cal_fail;
  logic next_cal_fail;
  logic [9:0] cnt;
  logic [9:0] next_cnt;
  logic [4:0] conv_left;
  logic [4:0] next_conv_left;
  logic [3:0] idx;
  logic [3:0] next_idx;
  logic [15:0] next_dac_code;
  logic signed [21:0] acc;
  logic signed [21:0] next_acc;
  logic [4:0] div_cnt;
  logic [4:0] next_div_cnt;
  logic [31:0] next_wb_dat_o;
  logic next_wb_ack_o;
  logic next_sample_hold;
  logic next_diff_mode;
  logic [1:0] next_reference_select;
  logic next_cal_short;
  logic next_async_clock_request;
  logic next_conv_irq;

  ////////////////////////////////////////////////////////////////////////////////
  // Derived configuration.

  logic cal_run;
  logic eff_diff;
  res_mode_t eff_mode;
  logic [4:0] nbits;
  logic [5:0] base_ticks;
  logic [5:0] lst_ticks;
  logic [5:0] sample_ticks;
  logic [2:0] first_ticks;
  logic [9:0] bus_limit;
  logic [5:0] ratio;
  logic tick;
  logic [4:0] nconv_m1;
  logic [2:0] avg_shift;
  logic [15:0] sar_final;
  logic [15:0] corrected;
  logic signed [21:0] acc_after;
  logic signed [21:0] mean;

  always_comb begin
    cal_run = ctrl[BIT_CAL];
    eff_diff = ctrl[BIT_DIFF] & ~cal_run;
    eff_mode = cal_run ? RES_16 : res_mode_t'(ctrl[MODE_LSB +: 2]);
    unique case (eff_mode)
      RES_8: nbits = eff_diff ? 5'd9 : 5'd8;
      RES_12: nbits = eff_diff ? 5'd13 : 5'd12;
      RES_10: nbits = eff_diff ? 5'd11 : 5'd10;
      RES_16: nbits = 5'd16;
    endcase
    unique case (eff_mode)
      RES_8: base_ticks = eff_diff ? 6'(BCT_DIFF_9) : 6'(BCT_SE_8);
      RES_16: base_ticks = eff_diff ? 6'(BCT_DIFF_16) : 6'(BCT_SE_16);
      default: base_ticks = eff_diff ? 6'(BCT_DIFF_11_13) : 6'(BCT_SE_10_12);
    endcase
    unique case (ctrl[LSTS_LSB +: 3])
      3'h0: lst_ticks = 6'(LST_0);
      3'h1: lst_ticks = 6'(LST_1);
      3'h2: lst_ticks = 6'(LST_2);
      3'h3: lst_ticks = 6'(LST_3);
      default: lst_ticks = 6'h00;
    endcase
    if (!ctrl[BIT_LSMP]) begin
      lst_ticks = 6'h00;
    end
    // The sample phase absorbs the long sample and high speed adders; the SAR phase is one tick per bit.
    sample_ticks = base_ticks - 6'(nbits) + lst_ticks
                   + (ctrl[BIT_HSC] ? 6'(HSC_TICKS) : 6'h00);
    first_ticks = ctrl[BIT_LSMP] ? 3'(FIRST_TICKS_LONG) : 3'(FIRST_TICKS_SHORT);
    // A gated local clock needs time to restart before the first conversion.
    bus_limit = 10'(FIRST_BUS_CYCLES - 1);
    if (ctrl[BIT_ASYNC] && !ctrl[BIT_KEEP]) begin
      bus_limit = 10'(FIRST_BUS_CYCLES - 1 + FIRST_WAKE_CYCLES);
    end
    ratio = 6'(MIN_DIV) << ctrl[DIV_LSB +: 2];
    tick = ctrl[BIT_ASYNC] ? (lac_s2 & ~lac_s3) : (div_cnt == 5'(ratio - 6'd1));
    if (cal_run) begin
      avg_shift = 3'(CAL_AVG_SHIFT);
    end else if (ctrl[BIT_AVERAGING_ENABLE]) begin
      avg_shift = 3'd2 + {1'b0, ctrl[AVGS_LSB +: 2]};
    end else begin
      avg_shift = 3'd0;
    end
    nconv_m1 = 5'((6'd1 << avg_shift) - 6'd1);
    sar_final = dac_code;
    if (!comp_s2) begin
      sar_final[idx] = 1'b0;
    end
    acc_after = acc + (eff_diff ? {{6{corrected[15]}}, corrected} : {6'h00, corrected});
    mean = acc_after >>> avg_shift;
  end

  sar_result_corrector u_corrector (
    .raw(sar_final),
    .diff(eff_diff),
    .mode(eff_mode),
    .offset(cal_run ? 16'h0000 : offset),
    .gain(cal_run ? GAIN_RESET : gain),
    .corrected(corrected)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave and sequencer next state.

  logic bus_req;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic start_req;
  logic cal_req;

  always_comb begin
    next_state = state;
    next_ctrl = ctrl;
    next_offset = offset;
    next_gain = gain;
    next_result = result;
    next_conversion_complete_flag = conversion_complete_flag;
    next_cal_fail = cal_fail;
    next_cnt = cnt;
    next_conv_left = conv_left;
    next_idx = idx;
    next_dac_code = dac_code;
    next_acc = acc;
    next_div_cnt = (div_cnt >= 5'(ratio - 6'd1)) ? 5'h00 : div_cnt + 5'h01;
    bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wval = 32'h00000000;
    start_req = 1'b0;
    cal_req = 1'b0;
    next_wb_ack_o = bus_req;
    next_wb_dat_o = 32'h00000000;
    if (bus_req && wb_we_i) begin
      unique case (wb_adr_i)
        ADDR_CTRL: begin
          wval = (32'(ctrl) & ~wmask) | (wb_dat_i & wmask);
          next_ctrl = wval[CTRL_W-1:0];
          next_ctrl[BIT_START] = 1'b0;
          // Software can request calibration but never cancel one under way.
          next_ctrl[BIT_CAL] = ctrl[BIT_CAL] | (wval[BIT_CAL] & (state == ST_IDLE));
          start_req = wval[BIT_START] & (state == ST_IDLE);
          cal_req = wval[BIT_CAL] & ~ctrl[BIT_CAL] & (state == ST_IDLE);
          if (cal_req) begin
            next_cal_fail = 1'b0;
          end
        end
        ADDR_OFFSET: begin
          wval = ({16'h0000, offset} & ~wmask) | (wb_dat_i & wmask);
          next_offset = wval[15:0];
        end
        ADDR_GAIN: begin
          wval = ({16'h0000, gain} & ~wmask) | (wb_dat_i & wmask);
          next_gain = wval[15:0];
        end
        default: begin
        end
      endcase
    end else if (bus_req) begin
      unique case (wb_adr_i)
        ADDR_CTRL: next_wb_dat_o = 32'(ctrl);
        ADDR_STATUS: begin
          next_wb_dat_o[BIT_CONVERSION_COMPLETE_FLAG] = conversion_complete_flag;
          next_wb_dat_o[BIT_BUSY] = state != ST_IDLE;
          next_wb_dat_o[BIT_CALRUN] = cal_run;
          next_wb_dat_o[BIT_CALFAIL] = cal_fail;
        end
        ADDR_RESULT: begin
          next_wb_dat_o = {{16{eff_diff & result[15]}}, result};
          next_conversion_complete_flag = 1'b0;
        end
        ADDR_OFFSET: next_wb_dat_o = {16'h0000, offset};
        ADDR_GAIN: next_wb_dat_o = {16'h0000, gain};
        default: begin
        end
      endcase
    end
    unique case (state)
      ST_IDLE: begin
        if (start_req || cal_req) begin
          next_state = ST_ADDER_BUS;
          next_cnt = 10'h000;
        end
      end
      ST_ADDER_BUS: begin
        next_cnt = cnt + 10'h001;
        if (cnt == bus_limit) begin
          next_state = ST_ADDER_CLK;
          next_cnt = 10'h000;
        end
      end
      ST_ADDER_CLK: begin
        if (tick) begin
          next_cnt = cnt + 10'h001;
          if (cnt == 10'(first_ticks - 3'd1)) begin
            next_state = ST_SAMPLE;
            next_cnt = 10'h000;
            next_conv_left = nconv_m1;
            next_acc = 22'sh000000;
          end
        end
      end
      ST_SAMPLE: begin
        if (tick) begin
          next_cnt = cnt + 10'h001;
          if (cnt == 10'(sample_ticks - 6'd1)) begin
            next_state = ST_SAR;
            next_idx = 4'(nbits - 5'd1);
            next_dac_code = 16'(17'h00001 << (nbits - 5'd1));
          end
        end
      end
      ST_SAR: begin
        if (tick) begin
          next_dac_code = sar_final;
          if (idx != 4'h0) begin
            next_dac_code[idx - 4'h1] = 1'b1;
            next_idx = idx - 4'h1;
          end else if (conv_left != 5'h00) begin
            next_acc = acc_after;
            next_conv_left = conv_left - 5'h01;
            next_state = ST_SAMPLE;
            next_cnt = 10'h000;
          end else begin
            next_conversion_complete_flag = 1'b1;
            next_acc = 22'sh000000;
            next_cnt = 10'h000;
            next_conv_left = nconv_m1;
            if (cal_run) begin
              next_offset = mean[15:0];
              next_cal_fail = mean[15:0] > CAL_OFFSET_LIMIT;
              next_ctrl[BIT_CAL] = 1'b0;
              next_state = ST_IDLE;
            end else begin
              next_result = mean[15:0];
              // Continuous mode restarts without repeating the first adder.
              next_state = ctrl[BIT_CONT] ? ST_SAMPLE : ST_IDLE;
            end
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
    next_sample_hold = next_state == ST_SAMPLE;
    next_diff_mode = next_ctrl[BIT_DIFF] & ~next_ctrl[BIT_CAL];
    // An unused code reads back as is but drives the external pair.
    next_reference_select = (next_ctrl[REF_LSB +: 2] == 2'b11) ? 2'b00
                            : next_ctrl[REF_LSB +: 2];
    next_cal_short = next_ctrl[BIT_CAL];
    next_async_clock_request = next_ctrl[BIT_ASYNC]
                               & (next_ctrl[BIT_KEEP] | (next_state != ST_IDLE));
    next_conv_irq = next_conversion_complete_flag & next_ctrl[BIT_IE];
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      ctrl <= CTRL_RESET;
      offset <= OFFSET_RESET;
      gain <= GAIN_RESET;
      result <= 16'h0000;
      conversion_complete_flag <= 1'b0;
      cal_fail <= 1'b0;
      cnt <= 10'h000;
      conv_left <= 5'h00;
      idx <= 4'h0;
      dac_code <= 16'h0000;
      acc <= 22'sh000000;
      div_cnt <= 5'h00;
      wb_dat_o <= 32'h00000000;
      wb_ack_o <= 1'b0;
      sample_hold <= 1'b0;
      diff_mode <= 1'b0;
      reference_select <= 2'b00;
      cal_short <= 1'b0;
      async_clock_request <= 1'b0;
      conv_irq <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      ctrl <= next_ctrl;
      offset <= next_offset;
      gain <= next_gain;
      result <= next_result;
      conversion_complete_flag <= next_conversion_complete_flag;
      cal_fail <= next_cal_fail;
      cnt <= next_cnt;
      conv_left <= next_conv_left;
      idx <= next_idx;
      dac_code <= next_dac_code;
      acc <= next_acc;
      div_cnt <= next_div_cnt;
      wb_dat_o <= next_wb_dat_o;
      wb_ack_o <= next_wb_ack_o;
      sample_hold <= next_sample_hold;
      diff_mode <= next_diff_mode;
      reference_select <= next_reference_select;
      cal_short <= next_cal_short;
      async_clock_request <= next_async_clock_request;
      conv_irq <= next_conv_irq;
    end
  end

endmodule : sar_adc_conversion_sequencer

// file: testbench/sar_adc_conversion_sequencer_assertions.sv
`timescale 1ns/1ps
module sar_seq_checker (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clk_en,
  // Bus.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  // Front end.
  input wire logic sample_hold,
  input wire logic diff_mode,
  input wire logic [1:0] reference_select,
  input wire logic cal_short,
  input wire logic conv_irq
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  property p_ack_resp;
    wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en |=> wb_ack_o;
  endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("bus request not acked");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
  property p_dat_zero;
    !wb_ack_o |-> wb_dat_o == 32'h0;
  endproperty
  a_dat_zero: assert property (p_dat_zero) else $error("read data outside ack");
  property p_ref_reset;
    $rose(nrst) |-> reference_select == 2'b00;
  endproperty
  a_ref_reset: assert property (p_ref_reset) else $error("reference not external");
  property p_ref_code;
    reference_select != 2'b11;
  endproperty
  a_ref_code: assert property (p_ref_code) else $error("reserved reference code");
  property p_cal_se;
    cal_short |-> !diff_mode;
  endproperty
  a_cal_se: assert property (p_cal_se) else $error("calibration in differential");
  property p_sample_min;
    $rose(sample_hold) |=> sample_hold [*8];
  endproperty
  a_sample_min: assert property (p_sample_min) else $error("sample too short");
  property p_irq_fall;
    $fell(conv_irq) |-> wb_ack_o || $past(wb_ack_o);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
  // Continuous mode reenters sampling as the flag sets, so look one cycle back.
  property p_irq_rise;
    $rose(conv_irq) |-> !$past(sample_hold);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("flag set mid sample");
  c_irq: cover property ($rose(conv_irq));
  c_cal: cover property ($rose(cal_short));
  c_diff: cover property (diff_mode && sample_hold);
endmodule : sar_seq_checker

bind sar_adc_conversion_sequencer sar_seq_checker u_sar_seq_checker (
  .clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
  .sample_hold(sample_hold), .diff_mode(diff_mode),
  .reference_select(reference_select), .cal_short(cal_short), .conv_irq(conv_irq)
);

// file: testbench/sar_analog_model.sv
`timescale 1ns/1ps
module sar_analog_model (
  // From the sequencer.
  input wire logic [15:0] dac_code,
  input wire logic cal_short,
  input wire logic async_clock_request,
  // Levels in codes of the active format.
  input wire logic [15:0] vin,
  input wire logic [15:0] cal_lvl,
  // To the sequencer.
  output logic comparator_high,
  output logic local_async_clock
);
  logic [15:0] level;
  // The half code puts the input mid-code, so the search lands on the level itself.
  assign level = cal_short ? cal_lvl : vin;
  assign comparator_high = {level, 1'b1} > {dac_code, 1'b0};
  // The oscillator stands low while not requested.
  initial begin
    local_async_clock = 1'b0;
    forever begin
      #40;
      local_async_clock = async_clock_request ? !local_async_clock : 1'b0;
    end
  end
endmodule : sar_analog_model

// file: testbench/sar_adc_conversion_sequencer_tb_top.sv
`timescale 1ns/1ps
module sar_adc_conversion_sequencer_tb_top import sar_seq_pkg::*;;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_we_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic [15:0] vin = 16'h0;
  logic [15:0] cal_lvl = 16'h0;
  logic [31:0] wb_dat_o;
  logic [15:0] dac_code;
  logic [1:0] reference_select;
  logic wb_ack_o, comparator_high, local_async_clock, sample_hold, diff_mode;
  logic cal_short, async_clock_request, conv_irq;
  int num_errors = 0;
  int num_checks = 0;

  sar_adc_conversion_sequencer u_sar_adc_conversion_sequencer (
    .clk_sys(clk_sys), .nrst(nrst), .clk_en(1'b1), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .comparator_high(comparator_high), .local_async_clock(local_async_clock),
    .sample_hold(sample_hold), .dac_code(dac_code), .diff_mode(diff_mode),
    .reference_select(reference_select), .cal_short(cal_short),
    .async_clock_request(async_clock_request), .conv_irq(conv_irq));
  sar_analog_model u_sar_analog_model (
    .dac_code(dac_code), .cal_short(cal_short), .async_clock_request(async_clock_request),
    .vin(vin), .cal_lvl(cal_lvl), .comparator_high(comparator_high),
    .local_async_clock(local_async_clock));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk

  task automatic chk_time(input int g, input int e, input int tol);
    chk(32'(g > e - tol && g < e + tol), 32'h1, $sformatf("cycles %0d vs %0d", g, e));
  endtask : chk_time

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    @(posedge clk_sys);
    while (wb_ack_o !== 1'b1 && n < 50) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 50) num_errors++;
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_sys);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hf, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, 4'hf, q);
  endtask : rd

  function automatic int exp_cyc(input logic [20:0] c, input int t);
    int b, l, m;
    m = int'(c[4:3]);
    b = c[2] ? (m == 0 ? 27 : m == 3 ? 34 : 30) : (m == 0 ? 17 : m == 3 ? 25 : 20);
    l = 0;
    if (c[5] && c[8:6] < 4) l = c[8:6] == 0 ? 20 : c[8:6] == 1 ? 12 : c[8:6] == 2 ? 6 : 2;
    m = c[10] ? 4 << c[12:11] : 1;
    b = (c[5] ? 3 : 5) + m * (b + l + (c[9] ? 4 : 0));
    return 6 + (c[13] && !c[14] ? 500 : 0) + b * t;
  endfunction : exp_cyc

  // Start with the interrupt enabled, time it and read the result back.
  task automatic conv(input logic [20:0] c, output logic [31:0] r);
    int n, e, t;
    t = c[13] ? 8 : 4 << c[18:17];
    e = exp_cyc(c, t);
    wr(ADDR_CTRL, {11'h0, c | 21'h100001});
    n = 2;
    while (conv_irq !== 1'b1 && n < e + 100) begin
      @(posedge clk_sys);
      n++;
    end
    chk_time(n, e, t + 4);
    rd(ADDR_RESULT, r);
    chk(conv_irq, 0, "irq after read");
    chk(async_clock_request, c[13] & c[14], "clock request");
  endtask : conv

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [31:0] q;
    rd(ADDR_CTRL, q);
    chk(q, 32'(CTRL_RESET), "ctrl");
    rd(ADDR_GAIN, q);
    chk(q, 32'h8000, "gain");
    wr(ADDR_STATUS, 32'hf);
    rd(ADDR_STATUS, q);
    chk(q, 32'h0, "status");
    rd(8'h20, q);
    chk(q, 32'h0, "unmapped");
    chk(reference_select, 0, "ref pins");
    $display("test reset done");
  endtask : t_reset

  task automatic t_timing;
    logic [31:0] q;
    logic [20:0] cfg [22] = '{21'h0, 21'h8, 21'h10, 21'h18, 21'h4, 21'hc, 21'h14,
      21'h1c, 21'h20, 21'h60, 21'ha0, 21'he0, 21'h1a0, 21'h218, 21'h400, 21'hc00,
      21'h1400, 21'h1c00, 21'h4018, 21'h2018, 21'h6018, 21'h60000};
    foreach (cfg[i]) conv(cfg[i], q);
    $display("test timing done");
  endtask : t_timing

  task automatic t_cal(input logic [15:0] lvl, input logic f);
    int n;
    logic [31:0] q;
    cal_lvl <= lvl;
    wr(ADDR_CTRL, 32'h180000);
    n = 0;
    while (conv_irq !== 1'b1 && n < 20000) begin
      @(posedge clk_sys);
      n++;
    end
    chk(n < 20000, 1, "cal end");
    rd(ADDR_CTRL, q);
    chk(q[19], 0, "cal bit");
    rd(ADDR_STATUS, q);
    chk(q[3:2], {f, 1'b0}, "cal status");
    rd(ADDR_OFFSET, q);
    chk(q[15:0], lvl, "cal offset");
    rd(ADDR_RESULT, q);
    $display("test calibration done");
  endtask : t_cal

  task automatic t_result;
    logic [31:0] q;
    logic [20:0] c [8] = '{21'h18, 21'h18, 21'h18, 21'h1c, 21'h1c, 21'h4, 21'hc, 21'h1c00};
    logic [15:0] v [8] = '{16'h2000, 16'h2000, 16'h2000, 16'h9000, 16'h7000, 16'h80,
      16'h1800, 16'h5a};
    logic [15:0] o [8] = '{16'h0, 16'h10, 16'h10, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
    logic [15:0] g [8] = '{16'h8000, 16'h8000, 16'h4000, 16'h8000, 16'h8000, 16'h8000,
      16'h8000, 16'h8000};
    logic [31:0] e [8] = '{32'h2000, 32'h1ff0, 32'hff8, 32'h1000, 32'hfffff000,
      32'hffffff80, 32'h800, 32'h5a};
    foreach (c[i]) begin
      wr(ADDR_OFFSET, {16'h0, o[i]});
      wr(ADDR_GAIN, {16'h0, g[i]});
      vin <= v[i];
      conv(c[i], q);
      chk(q, e[i], "result");
    end
    bus(1'b1, ADDR_OFFSET, 32'h1234, 4'h1, q);
    rd(ADDR_OFFSET, q);
    chk(q, 32'h34, "offset lane");
    $display("test result done");
  endtask : t_result

  task automatic t_ref_irq;
    logic [31:0] q;
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CTRL, 32'(i) << REF_LSB);
      chk(reference_select, i == 3 ? 0 : i, "ref pins");
    end
    wr(ADDR_CTRL, 32'h19);
    repeat (exp_cyc(21'h18, 4) + 10) @(posedge clk_sys);
    chk(conv_irq, 0, "masked irq");
    rd(ADDR_STATUS, q);
    chk(q[1:0], 2'b01, "flag");
    wr(ADDR_CTRL, 32'h100000);
    repeat (2) @(posedge clk_sys);
    chk(conv_irq, 1, "unmasked irq");
    rd(ADDR_RESULT, q);
    $display("test reference and irq done");
  endtask : t_ref_irq

  // Continuous mode starts each new conversion at once, without the first adder.
  task automatic t_cont;
    int n;
    logic [31:0] q;
    wr(ADDR_OFFSET, 32'h0);
    vin <= 16'h0123;
    conv(21'h1a, q);
    chk(q, 32'h123, "cont first");
    n = 0;
    while (conv_irq !== 1'b1 && n < 200) begin
      @(posedge clk_sys);
      n++;
    end
    // The result read has already used three cycles of the next conversion.
    chk_time(n, BCT_SE_16 * 4 - 3, 2);
    rd(ADDR_RESULT, q);
    chk(q, 32'h123, "cont second");
    wr(ADDR_CTRL, 32'h100018);
    n = 0;
    while (conv_irq !== 1'b1 && n < 200) begin
      @(posedge clk_sys);
      n++;
    end
    rd(ADDR_STATUS, q);
    chk(q[1:0], 2'b01, "cont stop");
    rd(ADDR_RESULT, q);
    $display("test continuous done");
  endtask : t_cont

  //////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict

  // The whole run is near 20000 cycles; the watchdog allows 50000.
  initial begin
    #500_000;
    num_errors++;
    print_verdict();
  end

  initial begin
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_timing();
    t_cal(16'h200, 1'b1);
    t_cal(16'h20, 1'b0);
    t_result();
    t_ref_irq();
    t_cont();
    print_verdict();
  end
endmodule : sar_adc_conversion_sequencer_tb_top
